// file: test_vm_flags_and_index_regs.sv
// self-checking bench for the vm flag and index block
module test_vm_flags_and_index_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import vm_regs_pkg::*;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cmp_valid = 0, cmp_greater = 0, cmp_equal = 0;
  logic paper_out_evt = 0, forms_limit_evt = 0, arith_ovf_evt = 0, key_valid = 0, recovery_valid = 0, acc_req = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, acc_half, rv;
  logic [1:0] operator_key = 0, operator_recovery_routine = 0, flag_bit, idx_num;
  logic [3:0] acc_pos = 0, flag_group, digit_pos;
  logic [63:0] acc_wdata = 0, main_accumulator;
  logic [15:0] data_addr = 0, eff_addr, counter_reg_four, idx_operand;
  logic [12:0] instr_word;
  logic [2:0] instr_byte;
  logic [7:0] digit_word;
  logic flag_req, flag_result, idx_req, eff_scratch;
  flag_op_e flag_op;
  idx_op_e idx_op;
  acc_op_e acc_op = ACC_NOP;
  int err_count = 0, compares = 0, cyc = 0;
  always #2.5 clk = ~clk;
  vm_seq_model s (.clk, .flag_req, .flag_op, .flag_group, .flag_bit, .idx_req, .idx_op, .idx_num, .idx_operand);
  vm_flags_and_index_regs dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flag_req, .flag_op,
    .flag_group, .flag_bit, .flag_result, .cmp_valid, .cmp_greater, .cmp_equal, .paper_out_evt, .forms_limit_evt,
    .arith_ovf_evt, .key_valid, .operator_key, .recovery_valid, .operator_recovery_routine, .idx_req, .idx_op,
    .idx_num, .idx_operand, .acc_req, .acc_op, .acc_pos, .acc_wdata, .data_addr, .eff_addr, .eff_scratch,
    .instr_word, .instr_byte, .digit_word, .digit_pos, .acc_half, .main_accumulator, .counter_reg_four);
  task test_done;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [63:0] g, e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // register read: strobe one cycle, data in the following cycle
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 rv = reg_rdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // strobe bundle: compare, test events, key, recovery
  task evt(input logic [7:0] b, input logic [1:0] k);
    @(posedge clk);
    {cmp_valid, cmp_greater, cmp_equal, paper_out_evt, forms_limit_evt, arith_ovf_evt, key_valid, recovery_valid} <= b;
    operator_key <= k; operator_recovery_routine <= k;
    @(posedge clk);
    {cmp_valid, paper_out_evt, forms_limit_evt, arith_ovf_evt, key_valid, recovery_valid} <= 0;
    rd(8'h03);
  endtask
  task dec(input logic [15:0] a);
    @(posedge clk);
    data_addr <= a;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // one-cycle accumulator request, result looked at just after the edge
  task acc(input acc_op_e o, input logic [3:0] p, input logic [63:0] d);
    @(posedge clk);
    acc_req <= 1; acc_op <= o; acc_pos <= p; acc_wdata <= d;
    @(posedge clk);
    acc_req <= 0;
    #1;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      test_done;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 9; i++) begin
      rd(i[7:0]);
      chk(rv, 0);
    end
    rd(8'h20);
    chk(rv, 0);
    s.flag(FLAG_SET, 4'h5, 2'h2);
    rd(8'h02);
    chk(rv, 32'h0040_0000);
    s.flag(FLAG_INVERT, 4'h5, 2'h2);
    s.flag(FLAG_INVERT, 4'h5, 2'h1);
    s.flag(FLAG_TEST, 4'h5, 2'h1);
    #1 chk(flag_result, 1);
    rd(8'h02);
    chk(rv, 32'h0020_0000);
    s.flag(FLAG_CLEAR, 4'h5, 2'h1);
    rd(8'h02);
    chk(rv, 0);
    wr(8'h03, 32'ha000_0000);
    rd(8'h03);
    chk(main_accumulator[63:60], 4'ha);
    @(posedge clk);
    acc_req <= 1; acc_op <= ACC_LOAD; acc_wdata <= 64'h8000_0000_0abc_def1;
    @(posedge clk);
    acc_req <= 0;
    s.flag(FLAG_TEST, 4'hf, 2'h3);
    #1 chk(flag_result, 1);
    chk(acc_half, 32'h8abc_def1);
    s.flag(FLAG_SET, 4'hf, 2'h0);
    rd(8'h01);
    chk(rv, 32'h9000_0000);
    for (int i = 0; i < 3; i++) begin
      evt({1'b1, i == 0, i == 1, 5'h0}, 0);
      chk(rv[27:24], 4'h1 << (2 - i));
    end
    evt(8'b0001_1100, 0);
    chk(rv[23:20], 4'b1011);
    for (int k = 0; k < 4; k++) begin
      evt(8'h02, k[1:0]);
      chk(rv[19:16], 4'h1 << k);
      evt(8'h01, k[1:0]);
      chk(rv[15:12], 4'h1 << k);
    end
    s.idx(IDX_LOAD, 2'h3, 16'h0005);
    s.idx(IDX_SUB, 2'h3, 16'h0007);
    rd(8'h07);
    chk(rv, 32'h0000_fffe);
    chk(counter_reg_four[15], 1);
    rd(8'h03);
    chk(rv[22], 0);
    s.idx(IDX_LOAD, 2'h0, 16'hffff);
    s.idx(IDX_ADD, 2'h0, 16'h0001);
    rd(8'h03);
    chk(rv[22], 1);
    for (int n = 0; n < 3; n++)
      s.idx(IDX_LOAD, n[1:0], 16'(2 * n + 3));
    for (int x = 0; x < 4; x++) begin
      dec({14'h0040, x[1:0]});
      chk(eff_addr, {14'h0040 + 14'(x ? 2 * x + 1 : 0), x[1:0]});
    end
    dec(16'hefff);
    chk({eff_scratch, instr_word, instr_byte}, {1'b0, 13'h1dff, 3'h7});
    dec(16'hf5a3);
    chk({eff_scratch, digit_word, digit_pos}, {1'b1, 8'h5a, 4'h3});
    s.idx(IDX_INC, 2'h1, 16'h0000);
    rd(8'h05);
    chk(rv, 32'h0000_0006);
    acc(ACC_DIGIT, 4'h2, 64'h5);
    chk(main_accumulator, 64'h9000_0000_0abc_d5f1);
    acc(ACC_CHAR, 4'h5, 64'h77);
    chk(main_accumulator, 64'h9000_7700_0abc_d5f1);
    acc(ACC_HALF, 4'h0, 64'h1234_5678);
    chk(main_accumulator, 64'h1000_0000_0234_5678);
    chk(acc_half, 32'h1234_5678);
    acc(ACC_DIGIT, 4'hf, 64'h4);
    s.flag(FLAG_TEST, 4'hf, 2'h3);
    #1 chk(flag_result, 0);
    s.flag(FLAG_TEST, 4'hf, 2'h2);
    #1 chk(flag_result, 1);
    test_done;
  end
endmodule // test_vm_flags_and_index_regs

// file: vm_addr_decode.sv
// decoder for program-area and scratch-area address formats
`include "vm_regs_map.svh"
module vm_addr_decode (
  input wire logic [15:0] addr,
  output logic is_scratch,
  output logic [12:0] instr_word,
  output logic [2:0] byte_position_field,
  output logic [7:0] digit_word,
  output logic [3:0] digit_position_field,
  output logic [1:0] index_select_bits,
  output logic [13:0] data_word
);
  // scratch area when the top digit is all ones
  assign is_scratch = (addr[15:12] == `SCRATCH_DIGIT);
  // opcode byte in low three bits, word above
  assign byte_position_field = addr[2:0];
  assign instr_word = addr[15:3];
  // short unindexed digit form: eight word bits then digit
  assign digit_word = addr[11:4];
  assign digit_position_field = addr[3:0];
  // data address word part and index select
  assign index_select_bits = addr[1:0];
  assign data_word = addr[15:2];
endmodule // vm_addr_decode

// file: vm_flags_and_index_regs.sv
// vm architectural state: accumulator, index registers, condition word
//
// Summary of operation
// - top address digit all ones selects scratch area, else program area
// - instruction address low three bits give opcode byte in word
// - unindexed digit addresses use short form: eight word bits, four digit bits
// - half-word accumulator work uses low seven digits plus sign digit 15
// - accumulator is a full word, also written by digit or character
// - four index registers, sixteen bits, binary
// - first three give address offsets; fourth serves as counter
// - index offset counts 32-bit half-words
// - index arithmetic binary, two's-complement subtract, negative stored silently
// - one 64-bit condition word of sixteen four-bit groups
// - any flag may be set, cleared, inverted or tested; one is true
// - accumulator sign group is the same storage as accumulator digit 15
// - sign group: per thousand, per hundred, special, minus
// - compare updates greater, equal, less; fourth flag unused
// - test group: paper out, index overflow, forms limit, arithmetic overflow
// - key entry marks only the flag of the terminating operator key
// - recovery routine records shifted keys one to four in recovery group
// - other eleven groups general purpose, flags selected one to four
// - index select: 00 none, 01 first, 10 second, 11 third
//
// notes on timing and priority
// - every request is taken at the rising edge where its strobe is high
// - state, test result and decoded address appear one cycle later
// - read data stand only in the cycle after a read, zero otherwise
// - priority in one cycle, lowest first: accumulator work, flag op,
//   register flag write, compare, test events, key, recovery
// - hardware events win over a clear of the same flag in one cycle
// - digit 15 of the accumulator is kept only in the condition word,
//   so the two views can never disagree
// - a negative index result is stored silently; software tests bit 15
// - an index write from the register port loses to a sequencer request
// - decoded address outputs are registered
// - the effective word part wraps at fourteen bits; no carry is kept
// - a half-word write clears accumulator digits 14 to 7
// - unmapped register reads give zero, unmapped writes are ignored
`include "vm_regs_map.svh"
module vm_flags_and_index_regs
  import vm_regs_pkg::*;
#(
  parameter int IDX_WIDTH = 16,
  parameter int NUM_IDX = 4
) (
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flag operations
  input wire logic flag_req,
  input wire vm_regs_pkg::flag_op_e flag_op,
  input wire logic [3:0] flag_group,
  input wire logic [1:0] flag_bit,
  output logic flag_result,
  // compare result
  input wire logic cmp_valid,
  input wire logic cmp_greater,
  input wire logic cmp_equal,
  // console events
  input wire logic paper_out_evt,
  input wire logic forms_limit_evt,
  input wire logic arith_ovf_evt,
  input wire logic key_valid,
  input wire logic [1:0] operator_key,
  input wire logic recovery_valid,
  input wire logic [1:0] operator_recovery_routine,
  // index register operations
  input wire logic idx_req,
  input wire vm_regs_pkg::idx_op_e idx_op,
  input wire logic [1:0] idx_num,
  input wire logic [15:0] idx_operand,
  // accumulator operations
  input wire logic acc_req,
  input wire vm_regs_pkg::acc_op_e acc_op,
  input wire logic [3:0] acc_pos,
  input wire logic [63:0] acc_wdata,
  // address translation; accumulator and counter views
  input wire logic [15:0] data_addr,
  output logic [15:0] eff_addr,
  output logic eff_scratch,
  output logic [12:0] instr_word,
  output logic [2:0] instr_byte,
  output logic [7:0] digit_word,
  output logic [3:0] digit_pos,
  output logic [31:0] acc_half,
  output logic [63:0] main_accumulator,
  output logic [15:0] counter_reg_four
);
  import vm_regs_pkg::*;

  initial begin
    if (IDX_WIDTH != 16) $error("index width must be 16");
    if (NUM_IDX != 4) $error("exactly four index registers");
  end

  // accumulator digits 14..0; digit 15 lives in the condition word
  logic [59:0] acc_body_q, acc_body_d;
  logic [63:0] cond_q, cond_d;
  logic [IDX_WIDTH-1:0] idx_q [NUM_IDX];
  logic [IDX_WIDTH-1:0] idx_d;
  logic idx_we;
  logic [31:0] rdata_q, rdata_d;
  logic flag_res_q;
  logic [15:0] eff_q;
  logic eff_scr_q;
  logic [12:0] iword_q;
  logic [2:0] ibyte_q;
  logic [7:0] dword_q;
  logic [3:0] dpos_q;

  // flag index within the condition word
  function automatic logic [5:0] flag_index(input logic [3:0] grp, input logic [1:0] bit_sel);
    flag_index = {grp, bit_sel};
  endfunction

  // accumulator full view with sign digit taken from the sign group
  wire [63:0] acc_full = {cond_q[{`GRP_ACC, 2'h0} +: 4], acc_body_q};
  wire [5:0] sel_flag = flag_index(flag_group, flag_bit);
  wire flag_cur = cond_q[sel_flag];

  // address decoder
  wire dec_scratch;
  wire [12:0] dec_iword;
  wire [2:0] dec_ibyte;
  wire [7:0] dec_dword;
  wire [3:0] dec_dpos;
  wire [1:0] index_select_bits;
  wire [13:0] dec_data_word;
  vm_addr_decode u_dec (
    .addr(data_addr),
    .is_scratch(dec_scratch),
    .instr_word(dec_iword),
    .byte_position_field(dec_ibyte),
    .digit_word(dec_dword),
    .digit_position_field(dec_dpos),
    .index_select_bits(index_select_bits),
    .data_word(dec_data_word)
  );

  // indexing: offsets from first three registers only, in half-words
  wire [IDX_WIDTH-1:0] idx_offset = (index_select_bits == 2'h0) ? {IDX_WIDTH{1'b0}} :
                                    idx_q[index_select_bits - 2'h1];

  // keep the low fourteen bits of an offset; the word part is fourteen wide
  function automatic logic [13:0] offset_trim(input logic [15:0] v);
    offset_trim = v[13:0];
  endfunction

  // a half-word step is one unit above the two index-select bits
  wire [13:0] eff_word = dec_data_word + offset_trim(idx_offset);
  wire [15:0] eff_d = {eff_word, index_select_bits};

  // index arithmetic
  wire [IDX_WIDTH-1:0] alu_res;
  wire alu_ovf;
  vm_index_alu #(.WIDTH(IDX_WIDTH)) u_alu (
    .a(idx_q[idx_num]),
    .b(idx_operand),
    .op(idx_op),
    .result(alu_res),
    .overflow(alu_ovf)
  );
  assign idx_we = idx_req && (idx_op != IDX_NOP);
  assign idx_d = alu_res;

  // register-port write decodes
  wire wr_acc_lo = reg_wr && (reg_addr == `ADDR_ACC_LO);
  wire wr_acc_hi = reg_wr && (reg_addr == `ADDR_ACC_HI);
  wire wr_flags_lo = reg_wr && (reg_addr == `ADDR_FLAGS_LO);
  wire wr_flags_hi = reg_wr && (reg_addr == `ADDR_FLAGS_HI);
  wire wr_idx = reg_wr && (reg_addr[7:2] == 6'(`ADDR_IDX0 >> 2));

  // event images for the compare, test, key and recovery groups
  wire cmp_less = ~cmp_greater & ~cmp_equal;
  wire [3:0] key_onehot = 4'h1 << operator_key;
  wire [3:0] rec_onehot = 4'h1 << operator_recovery_routine;
  wire idx_ovf_evt = idx_we && alu_ovf;

  // accumulator value after this cycle's accumulator work
  logic [63:0] acc_new;

  // accumulator next value: full, digit, character or half-word write
  always_comb begin
    acc_new = acc_full;
    if (acc_req) begin
      case (acc_op)
        ACC_LOAD: acc_new = acc_wdata;
        ACC_DIGIT: acc_new[{acc_pos, 2'h0} +: 4] = acc_wdata[3:0];
        ACC_CHAR: acc_new[{acc_pos[2:0], 3'h0} +: 8] = acc_wdata[7:0];
        ACC_HALF: begin
          acc_new[59:0] = {32'h0, acc_wdata[27:0]};
          acc_new[63:60] = acc_wdata[31:28];
        end
        default: acc_new = acc_full;
      endcase
    end
    if (wr_acc_lo) acc_new[31:0] = reg_wdata;
    if (wr_acc_hi) acc_new[63:32] = reg_wdata;
    acc_body_d = acc_new[59:0];
  end

  // condition word next value, lowest priority first
  always_comb begin
    cond_d = cond_q;
    // sign digit lands in the sign group: minus, special, hundred, thousand
    cond_d[{`GRP_ACC, 2'h0} +: 4] = acc_new[63:60];
    // flag operations from the sequencer
    if (flag_req) begin
      case (flag_op)
        FLAG_SET: cond_d[sel_flag] = 1'b1;
        FLAG_CLEAR: cond_d[sel_flag] = 1'b0;
        FLAG_INVERT: cond_d[sel_flag] = ~flag_cur;
        default: cond_d[sel_flag] = flag_cur;
      endcase
    end
    if (wr_flags_lo) cond_d[31:0] = reg_wdata;
    if (wr_flags_hi) cond_d[63:32] = reg_wdata;
    // compare results; fourth flag left as is
    if (cmp_valid) begin
      cond_d[flag_index(`GRP_CMP, `FLG_GREATER)] = cmp_greater;
      cond_d[flag_index(`GRP_CMP, `FLG_EQUAL)] = cmp_equal;
      cond_d[flag_index(`GRP_CMP, `FLG_LESS)] = cmp_less;
    end
    // test-group flags set by hardware, winning over a clear
    if (paper_out_evt) cond_d[flag_index(`GRP_TST, `FLG_PAPER_OUT)] = 1'b1;
    if (forms_limit_evt) cond_d[flag_index(`GRP_TST, `FLG_FORMS_LIM)] = 1'b1;
    if (arith_ovf_evt) cond_d[flag_index(`GRP_TST, `FLG_ARITH_OVF)] = 1'b1;
    if (idx_ovf_evt) cond_d[flag_index(`GRP_TST, `FLG_INDEX_OVF)] = 1'b1;
    // one-hot key and recovery groups
    if (key_valid) cond_d[{`GRP_KEY, 2'h0} +: 4] = key_onehot;
    if (recovery_valid) cond_d[{`GRP_REC, 2'h0} +: 4] = rec_onehot;
  end


  // read mux; unmapped reads as zero
  always_comb begin
    case (reg_addr)
      `ADDR_ACC_LO: rdata_d = acc_full[31:0];
      `ADDR_ACC_HI: rdata_d = acc_full[63:32];
      `ADDR_FLAGS_LO: rdata_d = cond_q[31:0];
      `ADDR_FLAGS_HI: rdata_d = cond_q[63:32];
      `ADDR_IDX0: rdata_d = {16'h0, idx_q[0]};
      `ADDR_IDX1: rdata_d = {16'h0, idx_q[1]};
      `ADDR_IDX2: rdata_d = {16'h0, idx_q[2]};
      `ADDR_IDX3: rdata_d = {16'h0, idx_q[3]};
      `ADDR_STATUS: rdata_d = {31'h0, flag_res_q};
      default: rdata_d = 32'h0;
    endcase
    if (!reg_rd) rdata_d = 32'h0;
  end


  // architectural state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_body_q <= 60'h0;
      cond_q <= `RESET_WORD;
    end else begin
      acc_body_q <= acc_body_d;
      cond_q <= cond_d;
    end
  end


  // index registers; register-port write loads one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_IDX; i++) idx_q[i] <= `RESET_IDX;
    end else begin
      if (idx_we) idx_q[idx_num] <= idx_d;
      else if (wr_idx) idx_q[reg_addr[1:0]] <= reg_wdata[15:0];
    end
  end


  // test result and read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_res_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      if (flag_req && flag_op == FLAG_TEST) flag_res_q <= flag_cur;
      rdata_q <= rdata_d;
    end
  end


  // registered address translation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eff_q <= 16'h0;
      eff_scr_q <= 1'b0;
      iword_q <= 13'h0;
      ibyte_q <= 3'h0;
      dword_q <= 8'h0;
      dpos_q <= 4'h0;
    end else begin
      eff_q <= eff_d;
      eff_scr_q <= dec_scratch;
      iword_q <= dec_iword;
      ibyte_q <= dec_ibyte;
      dword_q <= dec_dword;
      dpos_q <= dec_dpos;
    end
  end


  // register port and test result outputs
  assign reg_rdata = rdata_q;
  assign flag_result = flag_res_q;

  // decoded address outputs
  assign eff_addr = eff_q;
  assign eff_scratch = eff_scr_q;
  assign instr_word = iword_q;
  assign instr_byte = ibyte_q;
  assign digit_word = dword_q;
  assign digit_pos = dpos_q;

  // half-word view: sign digit over low seven digits
  assign acc_half = {cond_q[{`GRP_ACC, 2'h0} +: 4], acc_body_q[27:0]};
  assign main_accumulator = acc_full;
  assign counter_reg_four = idx_q[3];
endmodule // vm_flags_and_index_regs

// file: vm_index_alu.sv
// binary two's-complement arithmetic for an index register
import vm_regs_pkg::*;
module vm_index_alu #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire vm_regs_pkg::idx_op_e op,
  output logic [WIDTH-1:0] result,
  output logic overflow
);
  logic [WIDTH:0] sum;
  initial begin
    if (WIDTH < 2) $error("index width too small");
  end
  // subtract by adding the complement; negative result stored silently
  assign sum = (op == IDX_SUB) ? ({1'b0, a} + {1'b0, ~b} + {{WIDTH{1'b0}}, 1'b1}) :
               (op == IDX_INC) ? ({1'b0, a} + {{WIDTH{1'b0}}, 1'b1}) :
               (op == IDX_ADD) ? ({1'b0, a} + {1'b0, b}) : {1'b0, b};
  assign result = sum[WIDTH-1:0];
  // carry out of an add or increment counts as overflow
  assign overflow = ((op == IDX_ADD) || (op == IDX_INC)) && sum[WIDTH];
endmodule // vm_index_alu

// file: vm_regs_checker_properties.sv
// assertion checker for the vm flag and index block
module vm_regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic flag_req,
  input wire vm_regs_pkg::flag_op_e flag_op,
  input wire logic [3:0] flag_group,
  input wire logic [1:0] flag_bit,
  input wire logic flag_result,
  input wire logic idx_req,
  input wire vm_regs_pkg::idx_op_e idx_op,
  input wire logic [1:0] idx_num,
  input wire logic [15:0] idx_operand,
  input wire logic acc_req,
  input wire logic [15:0] data_addr,
  input wire logic eff_scratch,
  input wire logic [2:0] instr_byte,
  input wire logic [7:0] digit_word,
  input wire logic [3:0] digit_pos,
  input wire logic [31:0] acc_half,
  input wire logic [63:0] main_accumulator,
  input wire logic [15:0] counter_reg_four
);
  timeunit 1ns;
  timeprecision 1ps;
  import vm_regs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // flag op on the sign group with no register write beside it
  wire sgn = flag_req && flag_group == 4'hf && !reg_wr;
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  acc_read_a: assert property (reg_rd && reg_addr == 8'h01 |=>
    reg_rdata == $past(main_accumulator[63:32])) else $error("accumulator read wrong");
  scratch_sel_a: assert property (1 |=> eff_scratch == (&$past(data_addr[15:12])))
    else $error("area select wrong");
  field_split_a: assert property (1 |=> instr_byte == $past(data_addr[2:0]) &&
    digit_pos == $past(data_addr[3:0]) && digit_word == $past(data_addr[11:4])) else $error("address fields wrong");
  half_view_a: assert property (acc_half == {main_accumulator[63:60], main_accumulator[27:0]})
    else $error("half view wrong");
  sign_set_a: assert property (sgn && flag_op == FLAG_SET |=> main_accumulator[60 + $past(flag_bit)])
    else $error("sign flag not set");
  sign_clear_a: assert property (sgn && flag_op == FLAG_CLEAR |=>
    !main_accumulator[60 + $past(flag_bit)]) else $error("sign flag not cleared");
  sign_invert_a: assert property (sgn && flag_op == FLAG_INVERT |=>
    main_accumulator[60 + $past(flag_bit)] != $past(main_accumulator[60 + flag_bit])) else $error("no invert");
  flag_test_a: assert property (flag_req && flag_op == FLAG_TEST && flag_group == 4'hf |=>
    flag_result == $past(main_accumulator[60 + flag_bit])) else $error("test result wrong");
  acc_hold_a: assert property (!acc_req && !reg_wr && !flag_req |=> $stable(main_accumulator))
    else $error("accumulator moved");
  count_load_a: assert property (idx_req && idx_op == IDX_LOAD && idx_num == 2'h3 && !reg_wr |=>
    counter_reg_four == $past(idx_operand)) else $error("counter load wrong");
  // main scenarios reached
  cover property (flag_req && flag_op == FLAG_TEST);
  cover property (idx_req && idx_op == IDX_SUB);
  cover property (reg_rd && reg_addr == 8'h01);
endmodule // vm_regs_checker
bind vm_flags_and_index_regs vm_regs_checker chk (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .flag_req,
  .flag_op, .flag_group, .flag_bit, .flag_result, .idx_req, .idx_op, .idx_num, .idx_operand, .acc_req, .data_addr,
  .eff_scratch, .instr_byte, .digit_word, .digit_pos, .acc_half, .main_accumulator, .counter_reg_four);

// file: vm_regs_map.svh
// register offsets, field positions and constants for the vm flag and index block
`ifndef VM_REGS_MAP_SVH
`define VM_REGS_MAP_SVH
// register word offsets on the plain register port
`define ADDR_ACC_LO 8'h00
`define ADDR_ACC_HI 8'h01
`define ADDR_FLAGS_LO 8'h02
`define ADDR_FLAGS_HI 8'h03
`define ADDR_IDX0 8'h04
`define ADDR_IDX1 8'h05
`define ADDR_IDX2 8'h06
`define ADDR_IDX3 8'h07
`define ADDR_STATUS 8'h08
// group numbers inside the condition word (group g at bits 4g+3..4g)
`define GRP_ACC 4'hf
`define GRP_CMP 4'he
`define GRP_TST 4'hd
`define GRP_KEY 4'hc
`define GRP_REC 4'hb
// flag positions inside a group
`define FLG_MINUS 2'h0
`define FLG_SPECIAL 2'h1
`define FLG_HUNDRED 2'h2
`define FLG_THOUSAND 2'h3
`define FLG_LESS 2'h0
`define FLG_EQUAL 2'h1
`define FLG_GREATER 2'h2
`define FLG_ARITH_OVF 2'h0
`define FLG_FORMS_LIM 2'h1
`define FLG_INDEX_OVF 2'h2
`define FLG_PAPER_OUT 2'h3
// address decoding field, accumulator layout and reset constants
`define SCRATCH_DIGIT 4'hf
`define ACC_SIGN_DIGIT 4'hf
`define HALF_DIGITS 7
`define RESET_WORD 64'h0
`define RESET_IDX 16'h0
`endif

// file: vm_regs_pkg.sv
// shared types for the vm flag and index block
package vm_regs_pkg;
  typedef enum logic [1:0] {FLAG_SET, FLAG_CLEAR, FLAG_INVERT, FLAG_TEST} flag_op_e;
  typedef enum logic [2:0] {IDX_NOP, IDX_LOAD, IDX_ADD, IDX_SUB, IDX_INC} idx_op_e;
  typedef enum logic [2:0] {ACC_NOP, ACC_LOAD, ACC_DIGIT, ACC_CHAR, ACC_HALF} acc_op_e;
  typedef logic [15:0] vaddr_t;
  typedef logic [1:0] idx_sel_t;
endpackage

// file: vm_seq_model.sv
// instruction sequencer model issuing flag and index operations
module vm_seq_model (
  input wire logic clk,
  output logic flag_req,
  output vm_regs_pkg::flag_op_e flag_op,
  output logic [3:0] flag_group,
  output logic [1:0] flag_bit,
  output logic idx_req,
  output vm_regs_pkg::idx_op_e idx_op,
  output logic [1:0] idx_num,
  output logic [15:0] idx_operand
);
  timeunit 1ns;
  timeprecision 1ps;
  import vm_regs_pkg::*;
  initial begin
    flag_req = 0; flag_op = FLAG_TEST; flag_group = 0; flag_bit = 0;
    idx_req = 0; idx_op = IDX_NOP; idx_num = 0; idx_operand = 0;
  end
  // one-cycle flag request, fields held with the strobe
  task flag(input flag_op_e o, input logic [3:0] g, input logic [1:0] b);
    @(posedge clk);
    flag_req <= 1; flag_op <= o; flag_group <= g; flag_bit <= b;
    @(posedge clk);
    flag_req <= 0;
  endtask
  // one-cycle index request
  task idx(input idx_op_e o, input logic [1:0] n, input logic [15:0] v);
    @(posedge clk);
    idx_req <= 1; idx_op <= o; idx_num <= n; idx_operand <= v;
    @(posedge clk);
    idx_req <= 0;
  endtask
endmodule // vm_seq_model
